// File: hdl/aps_pkg.sv
package aps_pkg;

  // ****************************************************************
  // Clock and time base.
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned CLK_PERIOD_NS = 40;

  // ****************************************************************
  // Power-up timing figures, each in its own unit.
  // ****************************************************************
  localparam int unsigned EXT_CLK_START_US = 50;
  localparam int unsigned OSC_START_US = 20;
  localparam int unsigned RESET_RELEASE_CLKS = 2;
  localparam int unsigned SETTLE_4K_CLKS = 2312;
  localparam int unsigned VALID_DATA_US_X10 = 22000;
  localparam int unsigned POWER_UP_MAX_US = 3000;

  // Cycle counts derived from the figures; least times round up.
  localparam int unsigned EXT_CLK_START_CYC = EXT_CLK_START_US * CLK_MHZ;
  localparam int unsigned OSC_START_CYC = OSC_START_US * CLK_MHZ;
  localparam int unsigned VALID_DATA_CYC = (VALID_DATA_US_X10 * CLK_MHZ + 9) / 10;
  localparam int unsigned POWER_UP_MAX_CYC = POWER_UP_MAX_US * CLK_MHZ;

  // ****************************************************************
  // Data rates, the counter width and the 4k conversion period in clock periods.
  // ****************************************************************
  localparam int unsigned RATE_W = 3;
  localparam int unsigned CNT_W = 17;
  localparam logic [RATE_W-1:0] RATE_4K = 3'h2;
  localparam logic [RATE_W-1:0] RATE_RESET = RATE_4K;

  // Period of one conversion at the 4k rate, in clock periods.
  localparam int unsigned CONV_PERIOD_4K = 512;

  // ****************************************************************
  // Host sequencer states.
  // ****************************************************************
  typedef enum logic [2:0] {
    APS_HS_OFF,
    APS_HS_WAIT_CLK,
    APS_HS_HOLD_RST,
    APS_HS_CONFIG,
    APS_HS_WAIT_VALID,
    APS_HS_RUN
  } aps_host_state_t;

endpackage

// File: hdl/aps_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// Pins between the host controller and the converter's sequencer.
interface aps_link_if;
  logic supply_ok;
  logic clk_run;
  logic reset_n;
  logic cfg_write;
  logic cfg_done;
  logic [aps_pkg::RATE_W-1:0] cfg_rate;
  logic conversion_ready_n;
  logic osc_run;

  modport dev (
    input supply_ok,
    input clk_run,
    input reset_n,
    input cfg_write,
    input cfg_done,
    input cfg_rate,
    output conversion_ready_n,
    output osc_run
  );

  modport host (
    output supply_ok,
    output clk_run,
    output reset_n,
    output cfg_write,
    output cfg_done,
    output cfg_rate,
    input conversion_ready_n,
    input osc_run
  );
endinterface
`default_nettype wire

// File: hdl/aps_device.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Host keeps all inputs low before power; cfg_rate is not cleared and sits at RATE_RESET from reset.
// - External clock starts 50 us after supply.
// - Internal oscillator starts 20 us after supply.
// - Reset held two clocks after first clock.
// - Reset rise releases filters, starts converting.
// - First ready fall: settled data, 2312 clocks.
// - After 2.2 ms, next fall marks valid data.
// - Host writes registers only after reset release.
// - Register write postpones settling start point.
// - Rate change restarts settling for new rate.
// - Sequence delivers data within 3 ms.
module aps_device (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic use_internal_osc,
  aps_link_if.dev link,
  output logic filters_running,
  output logic data_settled,
  output logic data_valid
);

  // ****************************************************************
  // Settling count for the selected rate.
  // ****************************************************************
  function automatic logic [aps_pkg::CNT_W-1:0] settle_of(input logic [2:0] rate);
    logic [aps_pkg::CNT_W-1:0] v;
    v = aps_pkg::CNT_W'(aps_pkg::SETTLE_4K_CLKS);
    // Each halving of the rate doubles the filter settling time.
    if (rate < aps_pkg::RATE_4K) begin
      v = v << (aps_pkg::RATE_4K - rate);
    end else begin
      v = v >> (rate - aps_pkg::RATE_4K);
    end
    return v;
  endfunction

  function automatic logic [aps_pkg::CNT_W-1:0] period_of(input logic [2:0] rate);
    logic [aps_pkg::CNT_W-1:0] v;
    v = aps_pkg::CNT_W'(aps_pkg::CONV_PERIOD_4K);
    if (rate < aps_pkg::RATE_4K) begin
      v = v << (aps_pkg::RATE_4K - rate);
    end else begin
      v = v >> (rate - aps_pkg::RATE_4K);
    end
    return v;
  endfunction

  logic supply_q;
  logic [aps_pkg::CNT_W-1:0] osc_cnt_q;
  logic osc_q;
  logic run_q;
  logic [aps_pkg::RATE_W-1:0] rate_q;
  logic [aps_pkg::CNT_W-1:0] settle_cnt_q;
  logic [aps_pkg::CNT_W-1:0] conv_cnt_q;
  logic [aps_pkg::CNT_W-1:0] stable_cnt_q;
  logic settled_q;
  logic stable_q;
  logic valid_q;
  logic ready_n_q;

  // ****************************************************************
  // Internal oscillator start delay after the supply is good.
  // ****************************************************************
  wire logic osc_due = osc_cnt_q >= aps_pkg::CNT_W'(aps_pkg::OSC_START_CYC);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_q <= 1'b0;
      osc_cnt_q <= '0;
      osc_q <= 1'b0;
    end else begin
      supply_q <= link.supply_ok;
      if (!supply_q) begin
        osc_cnt_q <= '0;
        osc_q <= 1'b0;
      end else if (!osc_due) begin
        osc_cnt_q <= osc_cnt_q + 1'b1;
      end else begin
        osc_q <= use_internal_osc;
      end
    end
  end

  // ****************************************************************
  // Filter reset, settling restart on writes, conversion pacing.
  // ****************************************************************
  // The clock only counts while the master clock runs or the oscillator does.
  wire logic clk_alive = link.clk_run | osc_q;
  wire logic running = link.reset_n & clk_alive;
  wire logic restart = link.cfg_done;
  wire logic settle_hit = settled_q == 1'b0 && settle_cnt_q == settle_of(rate_q);
  wire logic conv_hit = settled_q && conv_cnt_q == period_of(rate_q) - 1'b1;
  wire logic stable_due = stable_cnt_q >= aps_pkg::CNT_W'(aps_pkg::VALID_DATA_CYC);
  // A ready strobe is a low on every settled conversion; it lasts one cycle, two if cfg_write meets the period's last count.
  wire logic ready_fall = settle_hit | conv_hit;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
      rate_q <= aps_pkg::RATE_RESET;
      settle_cnt_q <= '0;
      conv_cnt_q <= '0;
      settled_q <= 1'b0;
    end else begin
      run_q <= running;
      if (!running) begin
        settle_cnt_q <= '0;
        conv_cnt_q <= '0;
        settled_q <= 1'b0;
        rate_q <= aps_pkg::RATE_RESET;
      end else if (restart) begin
        // Writes hold the settling start until their completion.
        rate_q <= link.cfg_rate;
        settle_cnt_q <= '0;
        conv_cnt_q <= '0;
        settled_q <= 1'b0;
      end else if (link.cfg_write) begin
        settle_cnt_q <= '0;
      end else if (settle_hit) begin
        settled_q <= 1'b1;
        conv_cnt_q <= '0;
      end else if (!settled_q) begin
        settle_cnt_q <= settle_cnt_q + 1'b1;
      end else if (conv_hit) begin
        conv_cnt_q <= '0;
      end else begin
        conv_cnt_q <= conv_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Stable-data window measured from reset release only.
  // ****************************************************************
  // Register writes do not restart this window; node settling is analog.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stable_cnt_q <= '0;
      stable_q <= 1'b0;
      valid_q <= 1'b0;
      ready_n_q <= 1'b1;
    end else begin
      ready_n_q <= ~(running & ready_fall);
      if (!running) begin
        stable_cnt_q <= '0;
        stable_q <= 1'b0;
        valid_q <= 1'b0;
      end else begin
        if (!stable_due) begin
          stable_cnt_q <= stable_cnt_q + 1'b1;
        end else begin
          stable_q <= 1'b1;
        end
        if (stable_q && ready_fall) begin
          valid_q <= 1'b1;
        end
        if (restart) begin
          valid_q <= 1'b0;
        end
      end
    end
  end

  assign link.conversion_ready_n = ready_n_q;
  assign link.osc_run = osc_q;
  assign filters_running = run_q;
  assign data_settled = settled_q;
  assign data_valid = valid_q;

endmodule
`default_nettype wire

// File: hdl/aps_host.sv
`timescale 1ns/10ps
`default_nettype none
module aps_host (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic power_good,
  input wire logic cfg_req,
  input wire logic [2:0] cfg_rate_in,
  aps_link_if.host link,
  output logic data_strobe,
  output logic seq_done
);

  aps_pkg::aps_host_state_t state_q;
  aps_pkg::aps_host_state_t state_d;
  logic [aps_pkg::CNT_W-1:0] cnt_q;
  logic supply_q;
  logic clk_q;
  logic rst_n_q;
  logic wr_q;
  logic done_q;
  logic [aps_pkg::RATE_W-1:0] rate_q;
  logic rdy_prev_q;
  logic strobe_q;
  logic seq_q;
  logic pending_q;

  // ****************************************************************
  // Sequencing decisions.
  // ****************************************************************
  wire logic clk_due = cnt_q >= aps_pkg::CNT_W'(aps_pkg::EXT_CLK_START_CYC);
  wire logic rst_due = cnt_q >= aps_pkg::CNT_W'(aps_pkg::RESET_RELEASE_CLKS);
  wire logic valid_due = cnt_q >= aps_pkg::CNT_W'(aps_pkg::VALID_DATA_CYC);
  wire logic rdy_fall = rdy_prev_q & ~link.conversion_ready_n;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      aps_pkg::APS_HS_OFF: if (power_good) state_d = aps_pkg::APS_HS_WAIT_CLK;
      aps_pkg::APS_HS_WAIT_CLK: if (clk_due) state_d = aps_pkg::APS_HS_HOLD_RST;
      aps_pkg::APS_HS_HOLD_RST: if (rst_due) state_d = aps_pkg::APS_HS_CONFIG;
      aps_pkg::APS_HS_CONFIG: state_d = aps_pkg::APS_HS_WAIT_VALID;
      aps_pkg::APS_HS_WAIT_VALID: if (valid_due && rdy_fall) state_d = aps_pkg::APS_HS_RUN;
      aps_pkg::APS_HS_RUN: state_d = aps_pkg::APS_HS_RUN;
      default: state_d = aps_pkg::APS_HS_OFF;
    endcase
    if (!power_good) begin
      state_d = aps_pkg::APS_HS_OFF;
    end
  end

  // ****************************************************************
  // State, delay counter and pin drivers.
  // ****************************************************************
  // The counter restarts on every state change so each wait is measured alone.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= aps_pkg::APS_HS_OFF;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
    end
  end

  // Configuration writes are only issued once reset is high.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_q <= 1'b0;
      clk_q <= 1'b0;
      rst_n_q <= 1'b0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      rate_q <= aps_pkg::RATE_RESET;
      pending_q <= 1'b0;
    end else begin
      supply_q <= state_d != aps_pkg::APS_HS_OFF;
      clk_q <= state_d != aps_pkg::APS_HS_OFF && state_d != aps_pkg::APS_HS_WAIT_CLK;
      rst_n_q <= state_d == aps_pkg::APS_HS_CONFIG || state_d == aps_pkg::APS_HS_WAIT_VALID
        || state_d == aps_pkg::APS_HS_RUN;
      pending_q <= cfg_req | (pending_q & ~done_q);
      wr_q <= rst_n_q & (cfg_req | pending_q) & ~wr_q & ~done_q;
      done_q <= wr_q;
      if (cfg_req) begin
        rate_q <= cfg_rate_in;
      end
    end
  end

  // Data before the stable window is discarded.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_prev_q <= 1'b1;
      strobe_q <= 1'b0;
      seq_q <= 1'b0;
    end else begin
      rdy_prev_q <= link.conversion_ready_n;
      strobe_q <= state_q == aps_pkg::APS_HS_RUN && rdy_fall;
      seq_q <= state_q == aps_pkg::APS_HS_RUN;
    end
  end

  assign link.supply_ok = supply_q;
  assign link.clk_run = clk_q;
  assign link.reset_n = rst_n_q;
  assign link.cfg_write = wr_q;
  assign link.cfg_done = done_q;
  assign link.cfg_rate = rate_q;
  assign data_strobe = strobe_q;
  assign seq_done = seq_q;

endmodule
`default_nettype wire

// File: dv/aps_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Power-up sequencing checks on the host to converter link.
// ****************************************************************
module aps_sva (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic supply_ok,
  input wire logic clk_run,
  input wire logic reset_n,
  input wire logic cfg_write,
  input wire logic cfg_done,
  input wire logic [aps_pkg::RATE_W-1:0] cfg_rate,
  input wire logic conversion_ready_n,
  input wire logic osc_run
);
  logic [16:0] sup_cnt_q;
  logic [16:0] run_cnt_q;
  logic [9:0] gap_q;
  logic rdy_prev_q;
  logic seen_q;
  wire logic rdy_fall;
  wire logic restart;
  wire logic rate_4k;
  // A held reset or any write restarts settling, so the count anchors there.
  assign rdy_fall = rdy_prev_q & ~conversion_ready_n;
  assign restart = ~reset_n | cfg_write | cfg_done;
  assign rate_4k = (cfg_rate == aps_pkg::RATE_4K);
  // Counters saturate instead of wrapping, so a long run never fakes an early edge.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sup_cnt_q <= 17'h0;
      run_cnt_q <= 17'h0;
      gap_q <= 10'h0;
      rdy_prev_q <= 1'b1;
      seen_q <= 1'b0;
    end else begin
      sup_cnt_q <= !supply_ok ? 17'h0 : sup_cnt_q + {16'h0, ~&sup_cnt_q};
      run_cnt_q <= restart ? 17'h0 : run_cnt_q + {16'h0, ~&run_cnt_q};
      gap_q <= rdy_fall ? 10'h1 : gap_q + {9'h0, ~&gap_q};
      rdy_prev_q <= conversion_ready_n;
      seen_q <= !restart & (seen_q | rdy_fall);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_write;
    cfg_write ##1 cfg_done;
  endsequence
  sequence s_first_fall;
    rdy_fall && !seen_q && rate_4k;
  endsequence
  inputs_low_a: assert property (!supply_ok |-> !clk_run && !reset_n && !cfg_write)
    else $error("link input active before supply");
  clk_start_a: assert property ($rose(clk_run) |-> sup_cnt_q >= aps_pkg::EXT_CLK_START_CYC)
    else $error("clock started too early");
  // The supply counter stands in for a long delay range: the clock must be up by 1300.
  clk_bound_a: assert property (supply_ok && !clk_run |-> sup_cnt_q <= 17'd1300)
    else $error("clock never started");
  osc_start_a: assert property ($rose(osc_run) |-> sup_cnt_q >= aps_pkg::OSC_START_CYC)
    else $error("oscillator started too early");
  reset_hold_a: assert property ($rose(reset_n) |-> $past(clk_run, 2))
    else $error("reset released too soon after clock");
  no_early_ready_a: assert property (!reset_n |-> conversion_ready_n)
    else $error("ready pulse while in reset");
  ready_pulse_a: assert property (!conversion_ready_n |=> conversion_ready_n)
    else $error("ready low longer than one cycle");
  ready_period_a: assert property (rdy_fall && seen_q && rate_4k |-> gap_q == 10'h200)
    else $error("ready period wrong");
  cfg_order_a: assert property (cfg_write |-> reset_n)
    else $error("write before reset release");
  cfg_pair_a: assert property (cfg_write |-> s_write)
    else $error("write without completion");
  settle_time_a: assert property (s_first_fall |-> run_cnt_q inside {[2312:2316]})
    else $error("first settled data at wrong time");
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct {int lo; int hi;} aps_note_t;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic power_good = 1'b0;
  logic cfg_req = 1'b0;
  logic [2:0] cfg_rate_in = 3'h2;
  logic use_osc = 1'b0;
  logic filters_running, data_settled, data_valid, data_strobe, seq_done;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int t_sup, t_clk, t_rst, t_anc, t_pg;
  logic p_pg, p_sup, p_clk, p_rst, p_rdy, p_val, first;
  logic [31:0] seed = 32'h5c6730ce;
  aps_note_t notes[$];
  aps_link_if link ();
  aps_device aps_device_inst (.ref_clk(ref_clk), .arst_n(arst_n), .use_internal_osc(use_osc),
    .link(link), .filters_running(filters_running), .data_settled(data_settled),
    .data_valid(data_valid));
  aps_host aps_host_inst (.ref_clk(ref_clk), .arst_n(arst_n), .power_good(power_good),
    .cfg_req(cfg_req), .cfg_rate_in(cfg_rate_in), .link(link), .data_strobe(data_strobe),
    .seq_done(seq_done));
  aps_sva aps_sva_inst (.ref_clk(ref_clk), .arst_n(arst_n), .supply_ok(link.supply_ok),
    .clk_run(link.clk_run), .reset_n(link.reset_n), .cfg_write(link.cfg_write),
    .cfg_done(link.cfg_done), .cfg_rate(link.cfg_rate), .osc_run(link.osc_run),
    .conversion_ready_n(link.conversion_ready_n));
  // A 40 ns period, one inversion per half period.
  always #20 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic cmp_range(input string what, input int got, input aps_note_t n);
    checks_done++;
    if (got < n.lo || got > n.hi) begin
      n_fail++;
      $display("MISMATCH %0t %s: %0d not in %0d..%0d", $time, what, got, n.lo, n.hi);
    end
  endtask
  task automatic cmp_bit(input string what, input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s: %b not %b", $time, what, got, exp);
    end
  endtask
  task automatic take(input string what, input int got);
    if (notes.size() == 0) cmp_range(what, got, '{-1, -1});
    else cmp_range(what, got, notes.pop_front());
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // Monitor: time-stamps link edges and settles them against the notes.
  // ****************************************************************
  always @(posedge ref_clk) begin
    #1;
    cyc++;
    if (power_good && !p_pg) t_pg = cyc;
    if (link.supply_ok && !p_sup) t_sup = cyc;
    if (link.clk_run && !p_clk) begin
      take("clock start", cyc - t_sup);
      cmp_bit("filters before reset", filters_running, 1'b0);
      t_clk = cyc;
    end
    if (link.reset_n && !p_rst) begin
      take("reset release", cyc - t_clk);
      t_rst = cyc;
      t_anc = cyc;
      first = 1'b1;
    end
    if (link.cfg_done) t_anc = cyc;
    if (!link.conversion_ready_n && p_rdy && first) begin
      take("first settled", cyc - t_anc);
      cmp_bit("filters running", filters_running, 1'b1);
      first = 1'b0;
    end
    if (data_valid && !p_val) begin
      take("valid data", cyc - t_rst);
      take("power-up time", cyc - t_pg);
      cmp_bit("settled flag", data_settled, 1'b1);
    end
    if (data_strobe) cmp_bit("strobe before valid", data_valid & seq_done, 1'b1);
    {p_pg, p_sup, p_clk, p_rst} = {power_good, link.supply_ok, link.clk_run, link.reset_n};
    {p_rdy, p_val} = {link.conversion_ready_n, data_valid};
  end
  // ****************************************************************
  // Driver: one power-up, optionally with a write, noting what must follow.
  // ****************************************************************
  task automatic power_up(input bit cfg, input bit full);
    int i;
    seed = xs(seed);
    use_osc = full ? seed[0] : ~use_osc;
    notes.push_back('{aps_pkg::EXT_CLK_START_CYC, 1260});
    notes.push_back('{aps_pkg::RESET_RELEASE_CLKS, 8});
    notes.push_back('{aps_pkg::SETTLE_4K_CLKS, aps_pkg::SETTLE_4K_CLKS + 4});
    if (full) begin
      notes.push_back('{aps_pkg::VALID_DATA_CYC, aps_pkg::VALID_DATA_CYC + 516});
      notes.push_back('{0, aps_pkg::POWER_UP_MAX_CYC});
    end
    power_good = 1'b1;
    for (i = 0; i < 2000 && link.reset_n !== 1'b1; i++) @(negedge ref_clk);
    if (cfg) begin
      repeat (seed[9:0] + 1) @(negedge ref_clk);
      cfg_req = 1'b1;
      @(negedge ref_clk);
      cfg_req = 1'b0;
    end
    for (i = 0; i < 60000 && (full ? data_valid : data_settled) !== 1'b1; i++) begin
      @(negedge ref_clk);
    end
    repeat (1100) @(negedge ref_clk);
    $display("test done: write %0d full %0d at %0t", cfg, full, $time);
  endtask
  // Stimulus at the falling edge keeps it clear of the sampling edge.
  initial begin
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    power_up(1'b0, 1'b1);
    arst_n = 1'b0;
    power_good = 1'b0;
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    power_up(1'b1, 1'b0);
    close_out();
  end
  // Both runs together need about 65000 cycles; a hang stops at 80000.
  initial begin
    #(80000 * 40);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
